// >>> logic/mmpc_pkg.sv
// constants, codes and state types for the multi mode pulse counter
// assumes one 25 MHz clock and an AXI4-Lite master on the register side
// How it works
// - codes 0,1,3 pick dir/pulse, up/down, up count
// - codes 80,81,83 same counting, input inverted
// - codes 2,6,A pick frequency, adaptive/slow/fast gate
// - codes 82,86,8A frequency on inverted input
// - second input free for any single-input code
// - up count starts zero, wraps signed 32 bits
// - paired counts are signed, software bounds them
// - input pair 2k,2k+1 forms pair counter k
// - nonzero group filter drops short pulses, zero disables
package mmpc_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NCH = 8; // pulse inputs
    localparam int NGRP = 3; // filter groups
    localparam int CLK_HZ = 25_000_000; // aclk rate
    // ************************************************************
    // mode codes, bit 7 inverts the input
    // ************************************************************
    localparam int INV_BIT = 7; // inversion flag position
    localparam logic [6:0] K_DIRPUL = 7'h00; // pair, dir/pulse
    localparam logic [6:0] K_UPDN = 7'h01; // pair, up/down
    localparam logic [6:0] K_FRQA = 7'h02; // freq, adaptive gate
    localparam logic [6:0] K_UP = 7'h03; // single up count
    localparam logic [6:0] K_FRQS = 7'h06; // freq, slow gate
    localparam logic [6:0] K_FRQF = 7'h0A; // freq, fast gate
    localparam logic [7:0] MODE_RST = 8'h03; // up count at reset
    localparam logic [15:0] FILT_RST = 16'h0000; // filter off
    // ************************************************************
    // gate times
    // ************************************************************
    localparam int SLOW_GATE_MS = 1000; // slow_signal_gate_time
    localparam int FAST_GATE_MS = 100; // fast_signal_gate_time
    localparam int SLOW_GATE_CYC = CLK_HZ / 1000 * SLOW_GATE_MS;
    localparam int FAST_GATE_CYC = CLK_HZ / 1000 * FAST_GATE_MS;
    localparam logic [31:0] AUTO_THR = 32'h0000_0064; // adaptive pick
    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [7:0] WORD = 8'h04; // register stride
    localparam logic [7:0] MODE_BASE = 8'h00; // eight mode words
    localparam logic [7:0] FILT_BASE = 8'h20; // three filter words
    localparam logic [7:0] CLEAR_ADDR = 8'h2C; // clear mask, wo
    localparam logic [7:0] LEVEL_ADDR = 8'h30; // filtered levels
    localparam logic [7:0] COUNT_BASE = 8'h40; // eight counts
    localparam logic [1:0] RESP_OK = 2'h0; // axi okay
    localparam logic [1:0] RESP_ERR = 2'h2; // axi slverr
    // ************************************************************
    // state types
    // ************************************************************
    typedef struct packed {
        logic lvl; // filtered level
        logic rise; // rising edge pulse
        logic [15:0] stab; // stable-time counter
        logic [31:0] cnt; // count or frequency result
        logic [31:0] gate; // gate cycle counter
        logic [31:0] acc; // pulses in running gate
        logic slow; // adaptive gate uses slow
    } mmpc_chan_t;
    typedef struct packed {
        logic [NCH-1:0][7:0] mode; // per-input mode code
        logic [NGRP-1:0][15:0] filt; // input_glitch_filter_value
        logic [NCH-1:0] clr; // clear pulses
        logic aw_have; // write address held
        logic w_have; // write data held
        logic [7:0] awaddr; // held write address
        logic [31:0] wdata; // held write data
        logic [3:0] wstrb; // held byte enables
        logic awready; // aw channel ready
        logic wready; // w channel ready
        logic bvalid; // write response valid
        logic [1:0] bresp; // write response
        logic arready; // ar channel ready
        logic rvalid; // read data valid
        logic [1:0] rresp; // read response
        logic [31:0] rdata; // read data
    } mmpc_regs_t;
endpackage : mmpc_pkg

// >>> logic/mmpc_chan.sv
// one input lane: inversion, glitch filter, edge, count or frequency
// assumes sig_in synchronous to aclk; partner lane of the pair beside it
module mmpc_chan #(
    parameter bit IS_SECOND = 1'b0 // odd input of a pair
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire logic sig_in, // pulse input
    input wire logic [7:0] mode, // mode code
    input wire logic [15:0] filt, // filter width, cycles
    input wire logic clr, // clear count pulse
    input wire logic p_rise, // partner edge pulse
    input wire logic p_lvl, // partner filtered level
    input wire logic [31:0] slow_len, // slow gate cycles
    input wire logic [31:0] fast_len, // fast gate cycles
    input wire logic [31:0] auto_thr, // adaptive threshold
    output logic lvl_o, // filtered level
    output logic rise_o, // edge pulse
    output logic [31:0] count_o // count value
);
    // ************************************************************
    // state
    // ************************************************************
    mmpc_pkg::mmpc_chan_t q, d; // state and next
    logic raw; // input after inversion
    logic [6:0] kind; // mode without inversion
    logic [31:0] len; // active gate length
    assign raw = sig_in ^ mode[mmpc_pkg::INV_BIT];
    assign kind = mode[6:0];
    // slow gate for slow code, or adaptive after a small result
    assign len = (kind == mmpc_pkg::K_FRQS ||
                  (kind == mmpc_pkg::K_FRQA && q.slow)) ? slow_len
                                                        : fast_len;
    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = q;
        // filter: a new level must hold filt cycles to be taken
        if (filt == 16'h0000) begin
            d.lvl = raw;
            d.stab = 16'h0000;
        end else if (raw != q.lvl) begin
            if (q.stab >= filt - 16'h0001) begin
                d.lvl = raw;
                d.stab = 16'h0000;
            end else begin
                d.stab = q.stab + 16'h0001;
            end
        end else begin
            d.stab = 16'h0000; // glitch dropped
        end
        d.rise = d.lvl & ~q.lvl;
        unique case (kind)
            mmpc_pkg::K_UP: begin
                // plain wrap at the signed limit
                if (q.rise) d.cnt = q.cnt + 32'h0000_0001;
            end
            mmpc_pkg::K_DIRPUL: begin
                // odd lane reads zero, even lane holds pair count
                if (IS_SECOND) begin
                    d.cnt = 32'h0000_0000;
                end else if (q.rise) begin
                    d.cnt = p_lvl ? q.cnt + 32'h0000_0001
                                  : q.cnt - 32'h0000_0001;
                end
            end
            mmpc_pkg::K_UPDN: begin
                if (IS_SECOND) begin
                    d.cnt = 32'h0000_0000;
                end else if (q.rise && !p_rise) begin
                    d.cnt = q.cnt + 32'h0000_0001;
                end else if (!q.rise && p_rise) begin
                    d.cnt = q.cnt - 32'h0000_0001;
                end
            end
            mmpc_pkg::K_FRQA, mmpc_pkg::K_FRQS, mmpc_pkg::K_FRQF: begin
                // count edges over a gate, publish at its end
                if (q.gate >= len - 32'h0000_0001) begin
                    d.cnt = q.acc + {31'h0000_0000, q.rise};
                    d.acc = 32'h0000_0000;
                    d.gate = 32'h0000_0000;
                    d.slow = (d.cnt < auto_thr);
                end else begin
                    d.gate = q.gate + 32'h0000_0001;
                    d.acc = q.acc + {31'h0000_0000, q.rise};
                end
            end
            default: ; // unknown code: lane idles
        endcase
        if (clr) begin
            d.cnt = 32'h0000_0000;
            d.acc = 32'h0000_0000;
            d.gate = 32'h0000_0000;
        end
    end
    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) q <= '0;
        else q <= d;
    end
    assign lvl_o = q.lvl;
    assign rise_o = q.rise;
    assign count_o = q.cnt;
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    up_wrap_a: assert property (
        kind == mmpc_pkg::K_UP && q.rise && !clr
        |=> q.cnt == $past(q.cnt) + 32'h0000_0001)
        else $error("up count step wrong");
    inv_pass_a: assert property (
        filt == 16'h0000 |=> q.lvl == $past(raw))
        else $error("inverted level not passed");
    glitch_hold_a: assert property (
        filt != 16'h0000 && raw != q.lvl && q.stab < filt - 16'h0001
        |=> $stable(q.lvl))
        else $error("short pulse passed filter");
    dir_down_a: assert property (
        !IS_SECOND && kind == mmpc_pkg::K_DIRPUL && q.rise && !p_lvl
        && !clr |=> q.cnt == $past(q.cnt) - 32'h0000_0001)
        else $error("direction count wrong");
    updn_step_a: assert property (
        !IS_SECOND && kind == mmpc_pkg::K_UPDN && !q.rise && p_rise
        && !clr |=> q.cnt == $past(q.cnt) - 32'h0000_0001)
        else $error("down input not counted");
    second_zero_a: assert property (
        IS_SECOND && (kind == mmpc_pkg::K_UPDN ||
        kind == mmpc_pkg::K_DIRPUL) |=> q.cnt == 32'h0000_0000)
        else $error("odd lane not zero in pair mode");
    up_cover_c: cover property (kind == mmpc_pkg::K_UP && q.rise);
    gate_cover_c: cover property (kind == mmpc_pkg::K_FRQF &&
        q.gate == 32'h0000_0000 && q.cnt != 32'h0000_0000);
endmodule : mmpc_chan

// >>> logic/mmpc_top.sv
// pulse counter top: eight lanes behind an AXI4-Lite register slave
// assumes one outstanding read and one write from the master
//
// Chosen here: register access over AXI4-Lite and the register offsets.
module mmpc_top #(
    parameter int SLOW_CYC = mmpc_pkg::SLOW_GATE_CYC, // slow gate
    parameter int FAST_CYC = mmpc_pkg::FAST_GATE_CYC, // fast gate
    parameter logic [31:0] AUTO_THR = mmpc_pkg::AUTO_THR // adaptive
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire logic [mmpc_pkg::NCH-1:0] pulse_in, // pulse inputs
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    // ************************************************************
    // signals
    // ************************************************************
    localparam int N = mmpc_pkg::NCH; // lanes
    mmpc_pkg::mmpc_regs_t q, d; // register state and next
    logic [N-1:0] lvl_w; // lane filtered levels
    logic [N-1:0] rise_w; // lane edge pulses
    logic [N-1:0][31:0] count_w; // lane counts
    logic do_wr; // write performed this cycle
    logic wr_hit; // write address mapped
    logic rd_hit; // read address mapped
    logic [31:0] rd_data; // read mux result
    // ************************************************************
    // lanes
    // ************************************************************
    for (genvar i = 0; i < N; i++) begin : g_lane
        localparam int P = i ^ 1; // partner lane
        localparam int G = (i < 2) ? 0 : (i < 4) ? 1 : 2; // group
        mmpc_chan #(
            .IS_SECOND(i % 2 == 1)
        ) u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .sig_in(pulse_in[i]),
            .mode(q.mode[i]),
            .filt(q.filt[G]),
            .clr(q.clr[i]),
            .p_rise(rise_w[P]),
            .p_lvl(lvl_w[P]),
            .slow_len(32'(SLOW_CYC)),
            .fast_len(32'(FAST_CYC)),
            .auto_thr(AUTO_THR),
            .lvl_o(lvl_w[i]),
            .rise_o(rise_w[i]),
            .count_o(count_w[i])
        );
    end
    // ************************************************************
    // read decode
    // ************************************************************
    always_comb begin
        rd_hit = 1'b0;
        rd_data = 32'h0000_0000;
        for (int i = 0; i < N; i++) begin
            if (s_axi_araddr == mmpc_pkg::MODE_BASE +
                8'(i) * mmpc_pkg::WORD) begin
                rd_hit = 1'b1;
                rd_data = {24'h00_0000, q.mode[i]};
            end
            if (s_axi_araddr == mmpc_pkg::COUNT_BASE +
                8'(i) * mmpc_pkg::WORD) begin
                rd_hit = 1'b1;
                rd_data = count_w[i];
            end
        end
        for (int g = 0; g < mmpc_pkg::NGRP; g++) begin
            if (s_axi_araddr == mmpc_pkg::FILT_BASE +
                8'(g) * mmpc_pkg::WORD) begin
                rd_hit = 1'b1;
                rd_data = {16'h0000, q.filt[g]};
            end
        end
        if (s_axi_araddr == mmpc_pkg::CLEAR_ADDR) begin
            rd_hit = 1'b1; // reads zero
        end
        if (s_axi_araddr == mmpc_pkg::LEVEL_ADDR) begin
            rd_hit = 1'b1;
            rd_data = {24'h00_0000, lvl_w};
        end
    end
    // ************************************************************
    // bus and register next state
    // ************************************************************
    always_comb begin
        d = q;
        d.clr = '0;
        wr_hit = 1'b0;
        do_wr = q.aw_have && q.w_have && !q.bvalid;
        // take address and data in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
        // both halves held: write and answer
        if (do_wr) begin
            for (int i = 0; i < N; i++) begin
                if (q.awaddr == mmpc_pkg::MODE_BASE +
                    8'(i) * mmpc_pkg::WORD) begin
                    wr_hit = 1'b1;
                    if (q.wstrb[0]) d.mode[i] = q.wdata[7:0];
                end
            end
            for (int g = 0; g < mmpc_pkg::NGRP; g++) begin
                if (q.awaddr == mmpc_pkg::FILT_BASE +
                    8'(g) * mmpc_pkg::WORD) begin
                    wr_hit = 1'b1;
                    if (q.wstrb[0]) d.filt[g][7:0] = q.wdata[7:0];
                    if (q.wstrb[1]) d.filt[g][15:8] = q.wdata[15:8];
                end
            end
            if (q.awaddr == mmpc_pkg::CLEAR_ADDR) begin
                wr_hit = 1'b1;
                if (q.wstrb[0]) d.clr = q.wdata[N-1:0];
            end
            d.bvalid = 1'b1;
            d.bresp = wr_hit ? mmpc_pkg::RESP_OK : mmpc_pkg::RESP_ERR;
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
        end
        // read answers one cycle after the address is taken
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rdata = rd_data;
            d.rresp = rd_hit ? mmpc_pkg::RESP_OK : mmpc_pkg::RESP_ERR;
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;
        d.arready = !d.rvalid;
    end
    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.mode <= {N{mmpc_pkg::MODE_RST}};
            q.filt <= {mmpc_pkg::NGRP{mmpc_pkg::FILT_RST}};
        end else begin
            q <= d;
        end
    end
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    mode_write_a: assert property (
        do_wr && q.awaddr == mmpc_pkg::MODE_BASE && q.wstrb[0]
        |=> q.mode[0] == $past(q.wdata[7:0]))
        else $error("mode write not stored");
    filt_reset_a: assert property (
        $past(!aresetn) |-> q.filt == '0)
        else $error("filter not off after reset");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata))
        else $error("read data dropped");
    rd_lat_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_lat_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    pair_map_a: assert property (
        q.mode[2] == {1'b0, mmpc_pkg::K_UPDN} && !q.clr[2]
        && rise_w[2] && !rise_w[3]
        |=> count_w[2] == $past(count_w[2]) + 32'h0000_0001)
        else $error("pair two not counting");
    wr_cover_c: cover property (do_wr && wr_hit);
    rd_cover_c: cover property (s_axi_rvalid && s_axi_rready);
    err_cover_c: cover property (s_axi_bvalid &&
        s_axi_bresp == mmpc_pkg::RESP_ERR);
endmodule : mmpc_top

// >>> verif/mmpc_pulse_src.sv
// partner: pulse, level and square-wave sources on the eight inputs
// assumes lines change just after the rising edge of aclk
module mmpc_pulse_src (
    input wire logic aclk, // clock
    output logic [7:0] pulse_o // pulse lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] run_q = 8'h00; // lanes in free-run
    int ph = 0; // square-wave phase
    initial pulse_o = 8'h00;
    // free-run lanes: 2 high, 3 low, so one rise every 5 cycles
    always @(posedge aclk) begin
        ph <= (ph + 1) % 5;
        for (int i = 0; i < 8; i++) begin
            if (run_q[i]) pulse_o[i] <= (ph < 2);
        end
    end
    // n pulses w cycles wide; few pulses keep counts in range
    task automatic pulse(input int ln, input int n, input int w);
        repeat (n) begin
            @(posedge aclk);
            pulse_o[ln] <= 1'h1;
            repeat (w) @(posedge aclk);
            pulse_o[ln] <= 1'h0;
            repeat (w + 2) @(posedge aclk);
        end
    endtask : pulse
    // steady level, used as the direction line of a pair
    task automatic lvl(input int ln, input logic v);
        @(posedge aclk);
        pulse_o[ln] <= v;
    endtask : lvl
endmodule : mmpc_pulse_src

// >>> verif/mmpc_bench.sv
// bench for mmpc_top: axi-lite master, pulse partner, count model
// assumes logic/ compiled first; gates shortened to 40 and 10 cycles
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module mmpc_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // signals and model
    // ************************************************************
    logic aclk = 1'h0; // 25 MHz clock
    logic aresetn = 1'h0; // sync reset, low
    logic [7:0] pulse; // partner lines
    logic [7:0] awaddr = 8'h00; // write address
    logic [7:0] araddr = 8'h00; // read address
    logic [31:0] wdata = 32'h0000_0000; // write data
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0; // write side
    logic arvalid = 1'h0, rready = 1'h0; // read side
    logic awready, wready, bvalid, arready, rvalid; // slave handshakes
    logic [1:0] bresp, rresp; // responses
    logic [31:0] rdata, got; // read data, last read
    int failures = 0, n_tests = 0; // verdict counters
    int m_cnt [8]; // behavioural count model
    int a, b, c; // random pulse counts
    logic [7:0] fc [6] = '{8'h02, 8'h06, 8'h0A, 8'h82, 8'h86, 8'h8A};
    int fe [6] = '{8, 8, 2, 8, 8, 2}; // rises per gate at period 5
    always #20 aclk = ~aclk; // 40 ns period
    mmpc_pulse_src i_src (.aclk(aclk), .pulse_o(pulse));
    mmpc_top #(.SLOW_CYC(40), .FAST_CYC(10),
        .AUTO_THR(32'h0000_0064)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .pulse_in(pulse),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ************************************************************
    // bus tasks, sampled at the falling edge, driven after rising
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [7:0] ad, input logic [31:0] d,
            input logic [1:0] er);
        logic ha, hw, hb;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int k = 0; k < 40; k++) begin
            @(negedge aclk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid;
            @(posedge aclk);
            if (ha) awvalid <= 1'h0;
            if (hw) wvalid <= 1'h0;
            if (hb) begin
                bready <= 1'h0;
                `CHK(bresp, er)
                return;
            end
        end
        failures++;
        end_sim;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [1:0] er);
        logic ha, hr;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int k = 0; k < 40; k++) begin
            @(negedge aclk);
            ha = arvalid & arready;
            hr = rvalid;
            got = rdata;
            @(posedge aclk);
            if (ha) arvalid <= 1'h0;
            if (hr) begin
                rready <= 1'h0;
                `CHK(rresp, er)
                return;
            end
        end
        failures++;
        end_sim;
    endtask : rd
    // read one count word and compare with the model
    task automatic chk_cnt(input int i);
        rd(8'(8'h40 + 4 * i), 2'h0);
        `CHK(got, 32'(m_cnt[i]))
    endtask : chk_cnt
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(57523));
        cyc(3);
        aresetn <= 1'h1;
        cyc(2);
        // reset values, unmapped and read-only places
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), 2'h0);
            `CHK(got, 32'h0000_0003)
            m_cnt[i] = 0;
            chk_cnt(i);
        end
        rd(8'h20, 2'h0);
        `CHK(got, 32'h0000_0000)
        rd(8'h3C, 2'h2);
        wr(8'h40, 32'h0000_0001, 2'h2);
        // up count on input 0, inverted up count on its partner
        wr(8'h04, 32'h0000_0083, 2'h0);
        wr(8'h2C, 32'h0000_0002, 2'h0); // drop the inversion edge
        rd(8'h04, 2'h0);
        `CHK(got, 32'h0000_0083)
        a = $urandom_range(6, 1);
        i_src.pulse(0, a, 1);
        i_src.pulse(1, a, 1);
        m_cnt[0] = a;
        m_cnt[1] = a;
        cyc(4);
        chk_cnt(0);
        chk_cnt(1);
        // up/down pair on 2,3 and dir/pulse pair on 4,5
        for (int i = 2; i < 6; i++) begin
            wr(8'(4 * i), {31'h0, i < 4}, 2'h0);
        end
        i_src.lvl(5, 1'h0);
        wr(8'h2C, 32'h0000_003C, 2'h0); // zero the pair counts
        a = $urandom_range(6, 1);
        b = $urandom_range(6, 1);
        c = $urandom_range(6, 1);
        i_src.pulse(2, a, 1);
        i_src.pulse(3, b, 1);
        i_src.pulse(4, c, 1);
        i_src.lvl(5, 1'h1);
        i_src.pulse(4, 1, 1);
        m_cnt[2] = a - b;
        m_cnt[4] = 1 - c;
        cyc(4);
        for (int i = 2; i < 6; i++) begin
            chk_cnt(i);
        end
        // filtered levels: direction line 5 high, inverted input 1 idle
        rd(8'h30, 2'h0);
        `CHK(got, 32'h0000_0022)
        // glitch filter on group 0: short pulses dropped
        wr(8'h20, 32'h0000_0004, 2'h0);
        i_src.pulse(0, 3, 2);
        i_src.pulse(0, 2, 6);
        m_cnt[0] = m_cnt[0] + 2;
        chk_cnt(0);
        rd(8'h20, 2'h0);
        `CHK(got, 32'h0000_0004)
        // frequency codes on inputs 6 and 7 with a period-5 wave
        i_src.run_q <= 8'hC0;
        for (int i = 0; i < 6; i++) begin
            wr(8'h18, 32'(fc[i]), 2'h0);
            wr(8'h1C, 32'(fc[i]), 2'h0);
            cyc(150);
            rd(8'h58, 2'h0);
            `CHK(got, 32'(fe[i]))
            rd(8'h5C, 2'h0);
            `CHK(got, 32'(fe[i]))
        end
        end_sim;
    end
endmodule : mmpc_bench
